// ===== core/alu_io_regs.svh
`ifndef ALU_IO_REGS_SVH
`define ALU_IO_REGS_SVH

// ----
// I/O register offsets (short I/O address)
// ----
`define PB_INPUT_LEVELS           6'h03
`define PB_DIRECTION              6'h04
`define PB_OUTPUT_LATCH           6'h05
`define PC_INPUT_LEVELS           6'h06
`define PC_DIRECTION              6'h07
`define PC_OUTPUT_LATCH           6'h08
`define PD_INPUT_LEVELS           6'h09
`define PD_DIRECTION              6'h0a
`define PD_OUTPUT_LATCH           6'h0b
`define PA_INPUT_LEVELS           6'h0c
`define PA_DIRECTION              6'h0d
`define PA_OUTPUT_LATCH           6'h0e
`define PORT_DRIVE_PULLUP_CONTROL 6'h12
`define TIMER0_EVENT_FLAGS        6'h15
`define TIMER1_EVENT_FLAGS        6'h16

// ----
// Field masks and reset values
// ----
`define PA_BIT_MASK               8'h0f
`define FULL_BYTE_MASK            8'hff
`define TIMER0_FLAG_MASK          8'h07
`define TIMER1_FLAG_MASK          8'h27
`define IO_RESET_VALUE            8'h00

// ----
// Address spaces and cycle counts
// ----
`define BIT_IO_LAST               6'h1f
`define DATA_IO_OFFSET            8'h20
`define DATA_EXT_IO_FIRST         8'h60
`define WORD_PAIR_BASE            5'h18
`define GPR_COUNT                 32
`define SINGLE_OP_CYCLES          1
`define WORD_OP_CYCLES            2

`endif

// ===== core/alu_io_pkg.sv
package alu_io_pkg;

  typedef enum logic [4:0] {
    op_add                       = 5'h00,
    op_add_carry                 = 5'h01,
    op_word_immediate_increment  = 5'h02,
    op_subtract                  = 5'h03,
    op_difference_immediate      = 5'h04,
    op_difference_with_borrow    = 5'h05,
    op_difference_imm_borrow     = 5'h06,
    op_word_immediate_decrement  = 5'h07,
    op_and                       = 5'h08,
    op_mask_immediate            = 5'h09,
    op_or                        = 5'h0a,
    op_merge_immediate           = 5'h0b,
    op_xor_registers             = 5'h0c,
    op_invert_register           = 5'h0d,
    op_load_constant             = 5'h0e,
    op_io_read                   = 5'h0f,
    op_io_write                  = 5'h10,
    op_set_io_bit                = 5'h11,
    op_clear_io_bit              = 5'h12,
    op_skip_if_io_bit_high       = 5'h13,
    op_skip_if_io_bit_low        = 5'h14,
    op_memory_read               = 5'h15,
    op_memory_write              = 5'h16
  } op_type;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } sreg_type;

  typedef enum logic {
    seq_idle      = 1'b0,
    seq_word_high = 1'b1
  } seq_state_type;

endpackage : alu_io_pkg

// ===== core/alu_io_links.sv
`timescale 1ns/100ps

interface alu_link_if;
  alu_io_pkg::op_type   op;
  logic [7:0]           a;
  logic [7:0]           b;
  logic                 cin;
  logic                 phase_high;
  logic                 low_zero;
  alu_io_pkg::sreg_type flags_in;
  logic [7:0]           result;
  logic                 carry_out;
  alu_io_pkg::sreg_type flags_out;
  modport user (output op, a, b, cin, phase_high, low_zero, flags_in, input result, carry_out, flags_out);
  modport alu  (input op, a, b, cin, phase_high, low_zero, flags_in, output result, carry_out, flags_out);
endinterface : alu_link_if

interface io_link_if;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] wmask;
  logic       we;
  logic [7:0] rdata;
  modport host (output addr, wdata, wmask, we, input rdata);
  modport regs (input addr, wdata, wmask, we, output rdata);
endinterface : io_link_if

// ===== core/alu_core.sv
`timescale 1ns/100ps

module alu_core (
  alu_link_if.alu lnk
);

  logic                 sub;
  logic [8:0]           sum;
  logic [4:0]           half;
  logic [7:0]           r;
  logic                 ovf;
  alu_io_pkg::sreg_type f;

  always_comb begin
    sub = lnk.op inside {alu_io_pkg::op_subtract, alu_io_pkg::op_difference_immediate,
                         alu_io_pkg::op_difference_with_borrow, alu_io_pkg::op_difference_imm_borrow,
                         alu_io_pkg::op_word_immediate_decrement};
    if (sub) begin
      sum  = {1'b0, lnk.a} - {1'b0, lnk.b} - {8'h00, lnk.cin};
      half = {1'b0, lnk.a[3:0]} - {1'b0, lnk.b[3:0]} - {4'h0, lnk.cin};
      ovf  = (lnk.a[7] != lnk.b[7]) && (sum[7] != lnk.a[7]);
    end else begin
      sum  = {1'b0, lnk.a} + {1'b0, lnk.b} + {8'h00, lnk.cin};
      half = {1'b0, lnk.a[3:0]} + {1'b0, lnk.b[3:0]} + {4'h0, lnk.cin};
      ovf  = (lnk.a[7] == lnk.b[7]) && (sum[7] != lnk.a[7]);
    end
    r = sum[7:0];
    f = lnk.flags_in;
    case (lnk.op)
      alu_io_pkg::op_add, alu_io_pkg::op_add_carry, alu_io_pkg::op_subtract,
      alu_io_pkg::op_difference_with_borrow, alu_io_pkg::op_difference_immediate,
      alu_io_pkg::op_difference_imm_borrow: begin
        f.c = sum[8];
        f.h = half[4];
        f.v = ovf;
        f.n = r[7];
        f.z = (r == 8'h00);
      end
      alu_io_pkg::op_word_immediate_increment, alu_io_pkg::op_word_immediate_decrement: begin
        if (lnk.phase_high) begin
          f.c = sum[8];
          f.v = ovf;
          f.n = r[7];
          f.z = lnk.low_zero && (r == 8'h00);
          f.s = r[7] ^ ovf;
        end
      end
      alu_io_pkg::op_and, alu_io_pkg::op_mask_immediate: begin
        r   = lnk.a & lnk.b;
        f.v = 1'b0;
        f.n = r[7];
        f.z = (r == 8'h00);
      end
      alu_io_pkg::op_or, alu_io_pkg::op_merge_immediate: begin
        r   = lnk.a | lnk.b;
        f.v = 1'b0;
        f.n = r[7];
        f.z = (r == 8'h00);
      end
      alu_io_pkg::op_xor_registers: begin
        r   = lnk.a ^ lnk.b;
        f.v = 1'b0;
        f.n = r[7];
        f.z = (r == 8'h00);
      end
      alu_io_pkg::op_invert_register: begin
        r   = 8'hff - lnk.a;
        f.c = 1'b1;
        f.v = 1'b0;
        f.n = r[7];
        f.z = (r == 8'h00);
      end
      default: r = lnk.a;
    endcase
  end

  assign lnk.result    = r;
  assign lnk.carry_out = sum[8];
  assign lnk.flags_out = f;

endmodule : alu_core

// ===== core/io_space.sv
`timescale 1ns/100ps
`include "alu_io_regs.svh"

module io_space (
  input  wire logic            mclk,
  input  wire logic            reset_n,
  io_link_if.regs              lnk,
  input  wire logic [3:0][7:0] pins_in,
  input  wire logic [7:0]      timer0_set,
  input  wire logic [7:0]      timer1_set,
  output logic      [3:0][7:0] port_out,
  output logic      [3:0][7:0] port_oe,
  output logic      [3:0][7:0] port_pullup
);

  typedef struct packed {
    logic [3:0][7:0] sync_a;
    logic [3:0][7:0] sync_b;
    logic [3:0][7:0] dir;
    logic [3:0][7:0] latch;
    logic [3:0][7:0] pull;
    logic [7:0]      drive_ctl;
    logic [7:0]      tflag0;
    logic [7:0]      tflag1;
  } io_state_type;

  // Index 0..3 is port A, B, C, D
  localparam logic [3:0][5:0] PIN_BASE  = {`PD_INPUT_LEVELS, `PC_INPUT_LEVELS, `PB_INPUT_LEVELS, `PA_INPUT_LEVELS};
  localparam logic [3:0][7:0] PORT_MASK = {`FULL_BYTE_MASK, `FULL_BYTE_MASK, `FULL_BYTE_MASK, `PA_BIT_MASK};

  io_state_type q;
  io_state_type n;
  logic [7:0]   rd;
  logic [7:0]   hit;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data, input logic [7:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction : merge

  always_comb begin
    n        = q;
    rd       = 8'h00;
    hit      = lnk.wdata & lnk.wmask;
    n.sync_a = pins_in;
    n.sync_b = q.sync_a;
    for (int p = 0; p < 4; p++) begin
      if (lnk.addr == PIN_BASE[p])
        rd = q.sync_b[p] & PORT_MASK[p];
      if (lnk.addr == 6'(PIN_BASE[p] + 6'h01)) begin
        rd = q.dir[p];
        if (lnk.we)
          n.dir[p] = merge(q.dir[p], lnk.wdata, lnk.wmask) & PORT_MASK[p];
      end
      if (lnk.addr == 6'(PIN_BASE[p] + 6'h02)) begin
        rd = q.latch[p];
        if (lnk.we)
          n.latch[p] = merge(q.latch[p], lnk.wdata, lnk.wmask) & PORT_MASK[p];
      end
    end
    if (lnk.addr == `PORT_DRIVE_PULLUP_CONTROL) begin
      rd = q.drive_ctl;
      if (lnk.we)
        n.drive_ctl = merge(q.drive_ctl, lnk.wdata, lnk.wmask);
    end
    if (lnk.addr == `TIMER0_EVENT_FLAGS)
      rd = q.tflag0;
    if (lnk.addr == `TIMER1_EVENT_FLAGS)
      rd = q.tflag1;
    // Writing one clears a flag; a new event in the same cycle wins
    n.tflag0 = ((q.tflag0 & ~((lnk.we && lnk.addr == `TIMER0_EVENT_FLAGS) ? hit : 8'h00))
                | timer0_set) & `TIMER0_FLAG_MASK;
    n.tflag1 = ((q.tflag1 & ~((lnk.we && lnk.addr == `TIMER1_EVENT_FLAGS) ? hit : 8'h00))
                | timer1_set) & `TIMER1_FLAG_MASK;
    for (int p = 0; p < 4; p++)
      n.pull[p] = ~n.dir[p] & n.latch[p] & {8{~n.drive_ctl[p]}};
  end

  assign lnk.rdata = rd;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      q <= '0;
    else
      q <= n;
  end

  assign port_out    = q.latch;
  assign port_oe     = q.dir;
  assign port_pullup = q.pull;

endmodule : io_space

// ===== core/alu_and_io_space_access.sv
`timescale 1ns/100ps
`include "alu_io_regs.svh"

module alu_and_io_space_access #(
  parameter int GPR_COUNT = `GPR_COUNT
) (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                cmd_valid,
  input  wire alu_io_pkg::op_type  cmd_op,
  input  wire logic [4:0]          cmd_dst,
  input  wire logic [4:0]          cmd_src,
  input  wire logic [7:0]          cmd_imm,
  input  wire logic [2:0]          cmd_bit,
  input  wire logic [5:0]          cmd_io_addr,
  input  wire logic [7:0]          cmd_data_addr,
  input  wire logic [7:0]          timer0_events,
  input  wire logic [7:0]          timer1_events,
  input  wire logic [3:0][7:0]     port_pins_in,
  output logic                     cmd_busy,
  output logic                     done,
  output logic                     skip,
  output logic [7:0]               result,
  output alu_io_pkg::sreg_type     flags,
  output logic [3:0][7:0]          port_out,
  output logic [3:0][7:0]          port_oe,
  output logic [3:0][7:0]          port_pullup
);

  // ----
  // Parameter check
  // ----
  generate
    if (GPR_COUNT != 32) begin : gpr_check
      $error("register file must hold 32 bytes");
    end
  endgenerate

  // ----
  // State
  // ----
  typedef struct packed {
    logic [31:0][7:0]          gpr;
    alu_io_pkg::sreg_type      sreg;
    alu_io_pkg::seq_state_type st;
    logic                      word_dec;
    logic                      word_carry;
    logic                      word_zero;
    logic [4:0]                word_high;
    logic                      busy;
    logic                      done;
    logic                      skip;
    logic [7:0]                result;
  } top_state_type;

  top_state_type q;
  top_state_type n;

  alu_link_if alu ();
  io_link_if  io ();

  logic [4:0] word_lo;
  logic [5:0] data_io;
  logic [7:0] bit_sel;
  logic       bit_ok;
  logic       data_is_gpr;
  logic       data_is_io;
  logic       take;

  // ----
  // Submodules
  // ----
  alu_core u_alu (
    .lnk (alu.alu)
  );

  io_space u_io (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .lnk         (io.regs),
    .pins_in     (port_pins_in),
    .timer0_set  (timer0_events),
    .timer1_set  (timer1_events),
    .port_out    (port_out),
    .port_oe     (port_oe),
    .port_pullup (port_pullup)
  );

  // ----
  // Address decode
  // ----
  always_comb begin
    word_lo     = 5'(`WORD_PAIR_BASE + {2'b00, cmd_dst[1:0], 1'b0});
    data_io     = 6'(cmd_data_addr - `DATA_IO_OFFSET);
    bit_sel     = 8'(8'h01 << cmd_bit);
    bit_ok      = (cmd_io_addr <= `BIT_IO_LAST);
    data_is_gpr = (cmd_data_addr < `DATA_IO_OFFSET);
    data_is_io  = !data_is_gpr && (cmd_data_addr < `DATA_EXT_IO_FIRST);
    take        = cmd_valid && !q.busy;
  end

  // ----
  // Operand steering
  // ----
  always_comb begin
    alu.op         = cmd_op;
    alu.a          = q.gpr[cmd_dst];
    alu.b          = q.gpr[cmd_src];
    alu.cin        = 1'b0;
    alu.phase_high = 1'b0;
    alu.low_zero   = 1'b0;
    alu.flags_in   = q.sreg;
    io.addr        = cmd_io_addr;
    io.wdata       = q.gpr[cmd_dst];
    io.wmask       = 8'h00;
    io.we          = 1'b0;
    if (q.st == alu_io_pkg::seq_word_high) begin
      alu.op         = q.word_dec ? alu_io_pkg::op_word_immediate_decrement
                                  : alu_io_pkg::op_word_immediate_increment;
      alu.a          = q.gpr[q.word_high];
      alu.b          = 8'h00;
      alu.cin        = q.word_carry;
      alu.phase_high = 1'b1;
      alu.low_zero   = q.word_zero;
    end else if (take) begin
      case (cmd_op)
        alu_io_pkg::op_add_carry: begin
          alu.cin = q.sreg.c;
        end
        alu_io_pkg::op_difference_with_borrow: begin
          alu.cin = q.sreg.c;
        end
        alu_io_pkg::op_difference_immediate: begin
          alu.b = cmd_imm;
        end
        alu_io_pkg::op_difference_imm_borrow: begin
          alu.b   = cmd_imm;
          alu.cin = q.sreg.c;
        end
        alu_io_pkg::op_word_immediate_increment, alu_io_pkg::op_word_immediate_decrement: begin
          alu.a = q.gpr[word_lo];
          alu.b = {2'b00, cmd_imm[5:0]};
        end
        alu_io_pkg::op_mask_immediate, alu_io_pkg::op_merge_immediate: begin
          alu.b = cmd_imm;
        end
        alu_io_pkg::op_io_write: begin
          io.we    = 1'b1;
          io.wmask = 8'hff;
        end
        alu_io_pkg::op_set_io_bit: begin
          io.we    = bit_ok;
          io.wmask = bit_sel;
          io.wdata = bit_sel;
        end
        alu_io_pkg::op_clear_io_bit: begin
          io.we    = bit_ok;
          io.wmask = bit_sel;
          io.wdata = 8'h00;
        end
        alu_io_pkg::op_memory_read: begin
          io.addr = data_io;
        end
        alu_io_pkg::op_memory_write: begin
          io.addr  = data_io;
          io.we    = data_is_io;
          io.wmask = 8'hff;
        end
        default: begin
        end
      endcase
    end
  end

  // ----
  // Next state
  // ----
  always_comb begin
    n      = q;
    n.done = 1'b0;
    n.skip = 1'b0;
    case (q.st)
      alu_io_pkg::seq_word_high: begin
        n.gpr[q.word_high] = alu.result;
        n.sreg             = alu.flags_out;
        n.result           = alu.result;
        n.done             = 1'b1;
        n.busy             = 1'b0;
        n.st               = alu_io_pkg::seq_idle;
      end
      alu_io_pkg::seq_idle: begin
        if (take) begin
          n.done = 1'b1;
          case (cmd_op)
            alu_io_pkg::op_add, alu_io_pkg::op_add_carry, alu_io_pkg::op_subtract,
            alu_io_pkg::op_difference_immediate, alu_io_pkg::op_difference_with_borrow,
            alu_io_pkg::op_difference_imm_borrow, alu_io_pkg::op_and, alu_io_pkg::op_mask_immediate,
            alu_io_pkg::op_or, alu_io_pkg::op_merge_immediate, alu_io_pkg::op_xor_registers,
            alu_io_pkg::op_invert_register: begin
              n.gpr[cmd_dst] = alu.result;
              n.sreg         = alu.flags_out;
              n.result       = alu.result;
            end
            alu_io_pkg::op_word_immediate_increment, alu_io_pkg::op_word_immediate_decrement: begin
              // Low byte now, high byte and flags on the second cycle
              n.gpr[word_lo] = alu.result;
              n.word_high    = 5'(word_lo + 5'h01);
              n.word_carry   = alu.carry_out;
              n.word_zero    = (alu.result == 8'h00);
              n.word_dec     = (cmd_op == alu_io_pkg::op_word_immediate_decrement);
              n.busy         = 1'b1;
              n.done         = 1'b0;
              n.st           = alu_io_pkg::seq_word_high;
            end
            alu_io_pkg::op_load_constant: begin
              n.gpr[cmd_dst] = cmd_imm;
              n.result       = cmd_imm;
            end
            alu_io_pkg::op_io_read: begin
              n.gpr[cmd_dst] = io.rdata;
              n.result       = io.rdata;
            end
            alu_io_pkg::op_skip_if_io_bit_high: begin
              n.skip = bit_ok && io.rdata[cmd_bit];
            end
            alu_io_pkg::op_skip_if_io_bit_low: begin
              n.skip = bit_ok && !io.rdata[cmd_bit];
            end
            alu_io_pkg::op_memory_read: begin
              // Extended range has no register here and reads zero
              if (data_is_gpr) begin
                n.gpr[cmd_dst] = q.gpr[cmd_data_addr[4:0]];
                n.result       = q.gpr[cmd_data_addr[4:0]];
              end else if (data_is_io) begin
                n.gpr[cmd_dst] = io.rdata;
                n.result       = io.rdata;
              end else begin
                n.gpr[cmd_dst] = 8'h00;
                n.result       = 8'h00;
              end
            end
            alu_io_pkg::op_memory_write: begin
              if (data_is_gpr)
                n.gpr[cmd_data_addr[4:0]] = q.gpr[cmd_dst];
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        n.st   = alu_io_pkg::seq_idle;
        n.busy = 1'b0;
      end
    endcase
  end

  // ----
  // Registers
  // ----
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      q <= '0;
    else
      q <= n;
  end

  // ----
  // Outputs
  // ----
  assign cmd_busy = q.busy;
  assign done     = q.done;
  assign skip     = q.skip;
  assign result   = q.result;
  assign flags    = q.sreg;

endmodule : alu_and_io_space_access

// ===== verif/pin_partner.sv
`timescale 1ns/100ps

module pin_partner (
  input  wire logic [3:0][7:0] port_out,
  input  wire logic [3:0][7:0] port_oe,
  input  wire logic [3:0][7:0] port_pullup,
  input  wire logic [3:0][7:0] ext,
  output logic      [3:0][7:0] pins
);
  // ----
  // Pin level: driver, else pull-up, else outside
  // ----
  assign pins = (port_oe & port_out) | (~port_oe & (port_pullup | ext));
endmodule : pin_partner

// ===== verif/alu_and_io_space_access_monitor.sv
`timescale 1ns/100ps

module alu_and_io_space_access_monitor (
  input wire logic                 mclk,
  input wire logic                 reset_n,
  input wire logic                 cmd_valid,
  input wire alu_io_pkg::op_type   cmd_op,
  input wire logic [5:0]           cmd_io_addr,
  input wire logic                 cmd_busy,
  input wire logic                 done,
  input wire logic                 skip,
  input wire logic [7:0]           result,
  input wire alu_io_pkg::sreg_type flags,
  input wire logic [3:0][7:0]      port_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic take;
  logic wop;
  logic lop;
  logic aop;
  assign take = cmd_valid && !cmd_busy;
  assign wop  = cmd_op == alu_io_pkg::op_word_immediate_increment || cmd_op == alu_io_pkg::op_word_immediate_decrement;
  assign lop  = cmd_op >= alu_io_pkg::op_and && cmd_op <= alu_io_pkg::op_xor_registers;
  assign aop  = cmd_op <= alu_io_pkg::op_difference_imm_borrow && !wop;
  sequence s_word_take;
    take && wop;
  endsequence
  sequence s_word_finish;
    cmd_busy && !done ##1 done && !cmd_busy;
  endsequence
  a_word_two_cycles: assert property (s_word_take |=> s_word_finish)
    else $error("word op not done in two cycles");
  a_word_sign_flag: assert property (s_word_take |=> ##1 flags.s == (flags.n ^ flags.v))
    else $error("word op sign flag wrong");
  a_single_one_cycle: assert property (take && !wop |=> done && !cmd_busy)
    else $error("single op not done in one cycle");
  a_done_has_cause: assert property (done |-> $past(take) || $past(cmd_busy))
    else $error("done without command");
  a_arith_zero_neg: assert property (take && aop |=> flags.z == (result == 8'h00) && flags.n == result[7]
    && flags.s == $past(flags.s))
    else $error("arith flags wrong");
  a_logic_flags_kept: assert property (take && lop |=> $stable(flags.c) && $stable(flags.h) && $stable(flags.s)
    && flags.z == (result == 8'h00))
    else $error("logic op touched other flags");
  a_invert_carry_set: assert property (take && cmd_op == alu_io_pkg::op_invert_register |=> flags.c
    && !flags.v && flags.n == result[7])
    else $error("invert flags wrong");
  a_skip_with_done: assert property (skip |-> done)
    else $error("skip without done");
  a_high_no_skip: assert property (take && cmd_io_addr > 6'h1f && cmd_op >= alu_io_pkg::op_skip_if_io_bit_high
    && cmd_op <= alu_io_pkg::op_skip_if_io_bit_low |=> done && !skip)
    else $error("bit test above bit range");
  a_pa_upper_zero: assert property (port_out[0][7:4] == 4'h0)
    else $error("port A upper latch bits set");
  c_skip_seen: cover property (skip);
endmodule : alu_and_io_space_access_monitor

bind alu_and_io_space_access alu_and_io_space_access_monitor i_alu_and_io_space_access_monitor (
  .mclk, .reset_n, .cmd_valid, .cmd_op, .cmd_io_addr, .cmd_busy, .done, .skip, .result, .flags, .port_out);

// ===== verif/alu_and_io_space_access_tb_top.sv
`timescale 1ns/100ps

module alu_and_io_space_access_tb_top;
  logic                 mclk = 0, reset_n = 0, cmd_valid = 0, cmd_busy, done, skip, sk_exp = 0, rchk;
  alu_io_pkg::op_type   cmd_op = alu_io_pkg::op_add;
  alu_io_pkg::sreg_type flags, ef = '0;
  logic [4:0]           cmd_dst = 0, cmd_src = 0;
  logic [7:0]           cmd_imm = 0, cmd_data_addr = 0, t0 = 0, t1 = 0, result, er, io_exp;
  logic [2:0]           cmd_bit = 0;
  logic [5:0]           cmd_io_addr = 0;
  logic [3:0][7:0]      pins, ext = 0, p_out, p_oe, p_pu;
  logic [7:0]           gpr [32];
  int                   mismatches = 0, comparisons = 0, cyc = 0;

  alu_and_io_space_access i_alu_and_io_space_access (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_dst(cmd_dst), .cmd_src(cmd_src), .cmd_imm(cmd_imm), .cmd_bit(cmd_bit),
    .cmd_io_addr(cmd_io_addr), .cmd_data_addr(cmd_data_addr), .timer0_events(t0), .timer1_events(t1),
    .port_pins_in(pins), .cmd_busy(cmd_busy), .done(done), .skip(skip), .result(result), .flags(flags),
    .port_out(p_out), .port_oe(p_oe), .port_pullup(p_pu));
  pin_partner i_pin_partner (.port_out(p_out), .port_oe(p_oe), .port_pullup(p_pu), .ext(ext), .pins(pins));

  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  // ----
  // Expected register file and flags
  // ----
  task automatic model(input alu_io_pkg::op_type op, input logic [4:0] d, s, input logic [7:0] k);
    logic [8:0]  t;
    logic [7:0]  a, b;
    logic        ci;
    logic [4:0]  lo;
    logic [16:0] w;
    a = gpr[d];
    b = op inside {alu_io_pkg::op_difference_immediate, alu_io_pkg::op_difference_imm_borrow,
        alu_io_pkg::op_mask_immediate, alu_io_pkg::op_merge_immediate} ? k : gpr[s];
    ci = op inside {alu_io_pkg::op_add_carry, alu_io_pkg::op_difference_with_borrow,
                    alu_io_pkg::op_difference_imm_borrow} ? ef.c : 1'b0;
    lo = {2'b11, d[1:0], 1'b0};
    rchk = 1'b1;
    t = 9'h000;
    case (op)
      alu_io_pkg::op_word_immediate_increment, alu_io_pkg::op_word_immediate_decrement: begin
        w = (op == alu_io_pkg::op_word_immediate_increment) ? {gpr[lo + 1], gpr[lo]} + k[5:0]
          : {gpr[lo + 1], gpr[lo]} - k[5:0];
        ef.v = (op == alu_io_pkg::op_word_immediate_increment) ? !gpr[lo + 1][7] && w[15] : gpr[lo + 1][7] && !w[15];
        {ef.c, gpr[lo + 1], gpr[lo]} = w;
        ef.z = w[15:0] == 16'h0000;
        ef.n = w[15];
        ef.s = ef.n ^ ef.v;
        er = w[15:8];
      end
      alu_io_pkg::op_io_read, alu_io_pkg::op_memory_read: begin
        gpr[d] = io_exp;
        er = io_exp;
      end
      alu_io_pkg::op_io_write, alu_io_pkg::op_memory_write, alu_io_pkg::op_set_io_bit, alu_io_pkg::op_clear_io_bit,
      alu_io_pkg::op_skip_if_io_bit_high, alu_io_pkg::op_skip_if_io_bit_low: rchk = 1'b0;
      default: begin
        if (op <= alu_io_pkg::op_add_carry) begin
          t = a + b + ci;
          ef.h = (a[3:0] + b[3:0] + ci) > 5'h0f;
          ef.v = (a[7] == b[7]) && (t[7] != a[7]);
        end else if (op <= alu_io_pkg::op_difference_imm_borrow) begin
          t = a - b - ci;
          ef.h = {1'b0, a[3:0]} < b[3:0] + ci;
          ef.v = (a[7] != b[7]) && (t[7] != a[7]);
        end else if (op == alu_io_pkg::op_invert_register) t = {1'b1, ~a};
        else if (op == alu_io_pkg::op_load_constant) t = {ef.c, k};
        else begin
          t = {ef.c, op <= alu_io_pkg::op_mask_immediate ? a & b : op <= alu_io_pkg::op_merge_immediate ? a | b
            : a ^ b};
          ef.v = 1'b0;
        end
        if (op == alu_io_pkg::op_invert_register) ef.v = 1'b0;
        if (op != alu_io_pkg::op_load_constant) {ef.c, ef.z, ef.n} = {t[8], t[7:0] == 8'h00, t[7]};
        gpr[d] = t[7:0];
        er = t[7:0];
      end
    endcase
  endtask : model

  task automatic cmd(input alu_io_pkg::op_type op, input logic [4:0] d, s, input logic [7:0] k);
    @(posedge mclk);
    {cmd_valid, cmd_op, cmd_dst, cmd_src, cmd_imm, cmd_bit} <= {1'b1, op, d, s, k, s[2:0]};
    {cmd_io_addr, cmd_data_addr} <= {k[5:0], k};
    model(op, d, s, k);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    repeat (3) begin
      #1;
      if (done === 1'b1) break;
      @(posedge mclk);
    end
    chk({7'h00, done}, 8'h01);
    chk({7'h00, skip}, {7'h00, sk_exp});
    chk({2'b00, flags}, {2'b00, ef});
    if (rchk) chk(result, er);
  endtask : cmd

  task automatic rd(input alu_io_pkg::op_type op, input logic [7:0] a, input logic [7:0] e);
    io_exp = e;
    cmd(op, 5'd16, 5'd0, a);
  endtask : rd

  initial begin
    void'($urandom(32'hd83b0c14));
    foreach (gpr[i]) gpr[i] = 8'h00;
    ext = {$urandom};
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    cmd(alu_io_pkg::op_load_constant, 5'd24, 5'd0, 8'hff);
    cmd(alu_io_pkg::op_load_constant, 5'd25, 5'd0, 8'hff);
    cmd(alu_io_pkg::op_word_immediate_increment, 5'd0, 5'd0, 8'h01);
    cmd(alu_io_pkg::op_word_immediate_decrement, 5'd0, 5'd0, 8'h3f);
    repeat (150) cmd(alu_io_pkg::op_type'($urandom_range(0, 14)), 5'($urandom_range(16, 31)),
      5'($urandom_range(16, 31)), 8'($urandom));
    $display("alu test done");
    cmd(alu_io_pkg::op_load_constant, 5'd20, 5'd0, 8'ha5);
    cmd(alu_io_pkg::op_io_write, 5'd20, 5'd20, 8'h05);
    chk(p_out[1], 8'ha5);
    rd(alu_io_pkg::op_io_read, 8'h05, 8'ha5);
    cmd(alu_io_pkg::op_load_constant, 5'd21, 5'd0, 8'h3c);
    cmd(alu_io_pkg::op_memory_write, 5'd21, 5'd21, 8'h25);
    rd(alu_io_pkg::op_io_read, 8'h05, 8'h3c);
    rd(alu_io_pkg::op_memory_read, 8'h25, 8'h3c);
    cmd(alu_io_pkg::op_memory_write, 5'd21, 5'd21, 8'h60);
    rd(alu_io_pkg::op_memory_read, 8'h60, 8'h00);
    cmd(alu_io_pkg::op_io_write, 5'd20, 5'd20, 8'h12);
    rd(alu_io_pkg::op_io_read, 8'h17, 8'h00);
    cmd(alu_io_pkg::op_load_constant, 5'd22, 5'd0, 8'h07);
    cmd(alu_io_pkg::op_io_write, 5'd22, 5'd22, 8'h0e);
    rd(alu_io_pkg::op_io_read, 8'h0e, 8'h07);
    @(posedge mclk);
    {t0, t1} <= 16'hffff;
    @(posedge mclk);
    {t0, t1} <= 16'h0000;
    rd(alu_io_pkg::op_io_read, 8'h15, 8'h07);
    rd(alu_io_pkg::op_io_read, 8'h16, 8'h27);
    cmd(alu_io_pkg::op_set_io_bit, 5'd0, 5'd1, 8'h15);
    rd(alu_io_pkg::op_io_read, 8'h15, 8'h05);
    cmd(alu_io_pkg::op_clear_io_bit, 5'd0, 5'd0, 8'h15);
    rd(alu_io_pkg::op_io_read, 8'h15, 8'h05);
    cmd(alu_io_pkg::op_io_write, 5'd22, 5'd22, 8'h15);
    rd(alu_io_pkg::op_io_read, 8'h15, 8'h00);
    cmd(alu_io_pkg::op_set_io_bit, 5'd0, 5'd6, 8'h05);
    cmd(alu_io_pkg::op_clear_io_bit, 5'd0, 5'd2, 8'h05);
    rd(alu_io_pkg::op_io_read, 8'h05, 8'h78);
    sk_exp = 1'b1;
    cmd(alu_io_pkg::op_skip_if_io_bit_high, 5'd0, 5'd6, 8'h05);
    cmd(alu_io_pkg::op_skip_if_io_bit_low, 5'd0, 5'd0, 8'h05);
    sk_exp = 1'b0;
    cmd(alu_io_pkg::op_skip_if_io_bit_high, 5'd0, 5'd0, 8'h05);
    cmd(alu_io_pkg::op_skip_if_io_bit_low, 5'd0, 5'd0, 8'h25);
    cmd(alu_io_pkg::op_load_constant, 5'd23, 5'd0, 8'h0f);
    cmd(alu_io_pkg::op_io_write, 5'd23, 5'd23, 8'h04);
    repeat (3) @(posedge mclk);
    rd(alu_io_pkg::op_io_read, 8'h03, 8'h78 | (~8'h0f & ext[1]));
    $display("io test done");
    finish_test();
  end
endmodule : alu_and_io_space_access_tb_top
